// ===== src/hbah_defines.svh
// constants for the buffered host access port
// assumes a 200 MHz core clock standing in for the terminal input clock
`ifndef HBAH_DEFINES_SVH
`define HBAH_DEFINES_SVH

`define HBAH_CLK_PERIOD_PS     5000
`define HBAH_READY_CLKS        3
`define HBAH_GRANT_MAX_NS      2800
`define HBAH_GRANT_MAX_CLKS    ((`HBAH_GRANT_MAX_NS * 1000) / `HBAH_CLK_PERIOD_PS)
`define HBAH_REG_ADDR_W        5
`define HBAH_DATA_W            16
`define HBAH_ADDR_W            16
`define HBAH_CNT_W             4
`define HBAH_WAIT_W            16
`define HBAH_DATA_RST          16'h0000
`define HBAH_ADDR_RST          16'h0000
`define HBAH_CNT_RST           4'h0
`define HBAH_CNT_ONE           4'h1
`define HBAH_WAIT_RST          16'h0000
`define HBAH_WAIT_ONE          16'h0001
`define HBAH_STRAP_TRANSP      1'b0
`define HBAH_STRAP_ZERO_WAIT   1'b1
`define HBAH_STRAP_WIDTH       1'b1

`endif

// ===== src/hbah_pkg.sv
// types shared by the host access port and its storage
// assumes hbah_defines.svh is on the include path
`include "hbah_defines.svh"

package hbah_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SYNC,
        ST_ENABLED,
        ST_ACCESS,
        ST_READY
    } hbah_state_e;

    typedef logic [`HBAH_DATA_W-1:0] hbah_data_t;
    typedef logic [`HBAH_ADDR_W-1:0] hbah_addr_t;

    typedef struct packed {
        hbah_state_e             state;
        logic                    cs_s1;
        logic                    cs_s2;
        logic                    strobe_s1;
        logic                    strobe_s2;
        logic                    cs_prev;
        logic                    strobe_prev;
        hbah_addr_t              ale_addr;
        logic                    ale_mem_sel;
        logic                    ale_cs_n;
        logic                    mem_sel;
        logic                    is_read;
        hbah_addr_t              addr;
        hbah_data_t              wdata;
        logic                    extra;
        logic [`HBAH_CNT_W-1:0]  cnt;
        logic [`HBAH_WAIT_W-1:0] wait_cnt;
        logic                    wr_pulse;
        logic                    enable_n;
        logic                    ready_n;
        hbah_data_t              dout;
        logic                    doe;
        logic                    hold;
    } hbah_port_s;

endpackage

// ===== src/hbah_store.sv
// internal ram and register file reached by the host port
// assumes single clock; read is combinational from the held address
`timescale 1ns/1ps
`include "hbah_defines.svh"

module hbah_store
    import hbah_pkg::*;
#(
    parameter int RAM_ADDR_W = 12
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       write_in,
    input  wire logic       mem_sel_in,
    input  wire hbah_addr_t addr_in,
    input  wire hbah_data_t wdata_in,
    output      hbah_data_t rdata_out
);
    localparam int RAM_DEPTH = 1 << RAM_ADDR_W;
    localparam int REG_DEPTH = 1 << `HBAH_REG_ADDR_W;

    hbah_data_t ram_mem [RAM_DEPTH];
    hbah_data_t reg_mem [REG_DEPTH];

    logic [RAM_ADDR_W-1:0]       ram_idx;
    logic [`HBAH_REG_ADDR_W-1:0] reg_idx;

    // ram uses the low ram bits, registers only the low five
    assign ram_idx = addr_in[RAM_ADDR_W-1:0];
    assign reg_idx = addr_in[`HBAH_REG_ADDR_W-1:0];

    // ram array holds no reset
    always_ff @(posedge clk_in) begin
        if (write_in && mem_sel_in) begin
            ram_mem[ram_idx] <= wdata_in;
        end
    end

    // register file clears on reset
    genvar gi;
    generate
        for (gi = 0; gi < REG_DEPTH; gi++) begin : g_reg
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    reg_mem[gi] <= `HBAH_DATA_RST;
                end else if (write_in && !mem_sel_in && reg_idx == `HBAH_REG_ADDR_W'(gi)) begin
                    reg_mem[gi] <= wdata_in;
                end
            end
        end
    endgenerate

    // high select picks ram, low picks registers
    assign rdata_out = mem_sel_in ? ram_mem[ram_idx] : reg_mem[reg_idx];

endmodule

// ===== src/hbah_port.sv
// buffered 16-bit non-zero-wait host access port with handshake
// assumes host pins arrive on clk_in; select and strobe are resynchronised
// assumes the protocol engine reports ram use on ram_busy_in
// assumes the engine honours protocol_hold_out within one clock
// assumes straps stay put while a cycle is open
// assumes the host holds address, data and direction until ready falls
// assumes host pins never carry unknown levels once reset is released
`timescale 1ns/1ps
`include "hbah_defines.svh"

module hbah_port
    import hbah_pkg::*;
#(
    parameter int RAM_ADDR_W     = 12,
    parameter int GRANT_MAX_CLKS = `HBAH_GRANT_MAX_CLKS
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       host_select_n_in,
    input  wire logic       host_strobe_n_in,
    input  wire logic       mem_reg_sel_in,
    input  wire logic       read_write_in,
    input  wire logic       polarity_sel_strap_in,
    input  wire logic       transparent_sel_strap_in,
    input  wire logic       zero_wait_strap_in,
    input  wire logic       width_select_strap_in,
    input  wire logic       address_latch_enable_in,
    input  wire hbah_addr_t host_address_bus_in,
    input  wire hbah_data_t host_data_bus_in,
    input  wire logic       ram_busy_in,
    output      hbah_data_t host_data_bus_out,
    output      logic       host_data_bus_oe_out,
    output      logic       access_enable_n_out,
    output      logic       transfer_ready_n_out,
    output      logic       protocol_hold_out
);
    // grant limit cut to the wait counter width; keep the limit below 2**16 clocks
    // past the limit the host wins over the engine
    localparam logic [`HBAH_WAIT_W-1:0] GRANT_LIMIT = GRANT_MAX_CLKS[`HBAH_WAIT_W-1:0];

    // state register and its next value
    hbah_port_s port_reg;
    hbah_port_s port_next;

    // storage read port and combinational helpers
    hbah_data_t store_rdata;
    logic       straps_ok;
    logic       req_now;
    logic       req_split;
    logic       strobe_high;
    logic       can_grant;
    logic       req_valid;
    logic       track_pins;
    logic       dir_is_read;
    logic       ready_hit;
    logic       close_now;
    logic [`HBAH_CNT_W-1:0] ready_target;

    // storage behind the port
    // write pulse, select, address and data all come from registers
    hbah_store #(
        .RAM_ADDR_W (RAM_ADDR_W)
    ) u_store (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .write_in   (port_reg.wr_pulse),
        .mem_sel_in (port_reg.mem_sel),
        .addr_in    (port_reg.addr),
        .wdata_in   (port_reg.wdata),
        .rdata_out  (store_rdata)
    );

    // only the buffered, non-zero-wait, 16-bit configuration is served
    assign straps_ok = (transparent_sel_strap_in == `HBAH_STRAP_TRANSP)
                     && (zero_wait_strap_in == `HBAH_STRAP_ZERO_WAIT)
                     && (width_select_strap_in == `HBAH_STRAP_WIDTH);

    // synchronised request terms
    assign req_now     = !port_reg.cs_s2 && !port_reg.strobe_s2;
    assign strobe_high = port_reg.strobe_s2;

    // select and strobe first seen low on different edges marks a late arrival
    assign req_split = (port_reg.cs_prev != port_reg.strobe_prev);

    // after the wait limit the host wins over the protocol engine
    assign can_grant = !ram_busy_in || (port_reg.wait_cnt >= GRANT_LIMIT);

    // an inserted cycle pushes ready out by one clock
    assign ready_target = `HBAH_CNT_W'(`HBAH_READY_CLKS) + {{(`HBAH_CNT_W-1){1'b0}}, port_reg.extra};

    // a request counts only in the served strap configuration
    assign req_valid = req_now && straps_ok;

    // held fields follow the pins up to the latching edge
    assign track_pins = (port_reg.state == ST_IDLE) || (port_reg.state == ST_SYNC);

    // read when the direction pin matches the polarity strap
    assign dir_is_read = (read_write_in == polarity_sel_strap_in);

    // the counter has reached the edge that drops ready
    assign ready_hit = (port_reg.cnt == ready_target);

    // any open cycle ends once the released strobe has been synchronised
    assign close_now = (port_reg.state != ST_IDLE) && strobe_high;

    // next-state logic for the whole port
    // cycle outline, counted from the grant edge:
    //   grant: enable low, hold high, select, direction and address frozen
    //   +1: write data captured, write pulse raised
    //   +2: write word committed, read word registered and driven
    //   +3: ready low; the cycle then stays open while strobe is low
    //   an inserted cycle moves the freeze and every step after the grant one edge later
    // closing:
    //   strobe high reaches the synchroniser output two edges after the pin
    //   the next edge raises enable and ready, drops the drive and the hold
    //   a strobe released before ready aborts the cycle the same way
    //   select alone never closes a cycle, so the host may drop it early
    // contention:
    //   while ram_busy_in is high the request waits and the wait is counted
    //   at the grant limit the host wins and the engine is held off
    // hazards:
    //   a request that disappears while waiting clears the wait count
    //   straps outside the served set leave every request unanswered
    //   read data comes from the frozen address, never from the live pins
    // reset:
    //   all handshake outputs idle, select latch flop deselected
    //   synchronisers start high, so no false request follows reset
    always_comb begin
        // every field holds unless changed below; the write pulse lasts one clock
        port_next = port_reg;
        port_next.wr_pulse = 1'b0;

        // select is resynchronised behind its latch flop, one edge after strobe
        port_next.cs_s1       = port_reg.ale_cs_n;
        port_next.cs_s2       = port_reg.cs_s1;

        // strobe goes straight into its two-stage synchroniser
        port_next.strobe_s1   = host_strobe_n_in;
        port_next.strobe_s2   = port_reg.strobe_s1;

        // last synchronised levels, to tell a split arrival from a clean one
        port_next.cs_prev     = port_reg.cs_s2;
        port_next.strobe_prev = port_reg.strobe_s2;

        // address, select and memory select latches follow while latch enable is high
        if (address_latch_enable_in) begin
            port_next.ale_addr    = host_address_bus_in;
            port_next.ale_mem_sel = mem_reg_sel_in;
            port_next.ale_cs_n    = host_select_n_in;
        end

        // held fields track the pins until the cycle latches them
        if (track_pins) begin
            port_next.mem_sel = port_reg.ale_mem_sel;
            port_next.is_read = dir_is_read;
            port_next.addr    = port_reg.ale_addr;
        end

        unique case (port_reg.state)
            ST_IDLE: begin
                // grant when the ram is free or the wait has run out
                if (req_valid) begin
                    if (can_grant) begin
                        port_next.enable_n = 1'b0;
                        port_next.hold     = 1'b1;
                        port_next.cnt      = `HBAH_CNT_ONE;
                        port_next.extra    = req_split;
                        port_next.wait_cnt = `HBAH_WAIT_RST;
                        port_next.state    = req_split ? ST_SYNC : ST_ENABLED;
                    end else begin
                        port_next.wait_cnt = port_reg.wait_cnt + `HBAH_WAIT_ONE;
                    end
                end else begin
                    // no request pending, the wait starts over
                    port_next.wait_cnt = `HBAH_WAIT_RST;
                end
            end
            ST_SYNC: begin
                // one idle edge inserted before the write data is taken
                // select, direction and address still follow here and freeze on this edge
                port_next.cnt   = port_reg.cnt + `HBAH_CNT_ONE;
                port_next.state = ST_ENABLED;
            end
            ST_ENABLED: begin
                // fields stop following the pins and write data is taken
                // address stops following the latch flop from here on
                port_next.cnt   = port_reg.cnt + `HBAH_CNT_ONE;
                port_next.wdata = host_data_bus_in;
                port_next.wr_pulse = !port_reg.is_read;
                port_next.state = ST_ACCESS;
            end
            ST_ACCESS: begin
                // read data goes out before ready falls
                if (port_reg.is_read) begin
                    port_next.dout = store_rdata;
                    port_next.doe  = 1'b1;
                end
                // count up to the edge that drops ready
                if (ready_hit) begin
                    port_next.ready_n = 1'b0;
                    port_next.state   = ST_READY;
                end else begin
                    port_next.cnt = port_reg.cnt + `HBAH_CNT_ONE;
                end
            end
            ST_READY: begin
                // cycle stays open for as long as the strobe is low
                // the close below is the only way out
                port_next.state = ST_READY;
            end
        endcase

        // a released strobe ends any open cycle; select alone is not watched
        if (close_now) begin
            // handshake outputs return high together
            port_next.enable_n = 1'b1;
            port_next.ready_n  = 1'b1;
            // the data bus is released and the ram handed back
            port_next.doe      = 1'b0;
            port_next.hold     = 1'b0;
            // counters and the inserted-cycle flag start over
            port_next.cnt      = `HBAH_CNT_RST;
            port_next.extra    = 1'b0;
            port_next.state    = ST_IDLE;
        end
    end

    // single state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // synchronisers start at the idle level of their pins
            port_reg.state       <= ST_IDLE;
            port_reg.cs_s1       <= 1'b1;
            port_reg.cs_s2       <= 1'b1;
            port_reg.strobe_s1   <= 1'b1;
            port_reg.strobe_s2   <= 1'b1;
            port_reg.cs_prev     <= 1'b1;
            port_reg.strobe_prev <= 1'b1;

            // latch flops start deselected
            port_reg.ale_addr    <= `HBAH_ADDR_RST;
            port_reg.ale_mem_sel <= 1'b0;
            port_reg.ale_cs_n    <= 1'b1;

            // held cycle fields and counters
            port_reg.mem_sel     <= 1'b0;
            port_reg.is_read     <= 1'b0;
            port_reg.addr        <= `HBAH_ADDR_RST;
            port_reg.wdata       <= `HBAH_DATA_RST;
            port_reg.extra       <= 1'b0;
            port_reg.cnt         <= `HBAH_CNT_RST;
            port_reg.wait_cnt    <= `HBAH_WAIT_RST;

            // handshake, data drive and hold all idle
            port_reg.wr_pulse    <= 1'b0;
            port_reg.enable_n    <= 1'b1;
            port_reg.ready_n     <= 1'b1;
            port_reg.dout        <= `HBAH_DATA_RST;
            port_reg.doe         <= 1'b0;
            port_reg.hold        <= 1'b0;
        end else begin
            // every field moves together on the edge
            port_reg <= port_next;
        end
    end

    // outputs straight from the state register
    // read data and its drive enable
    assign host_data_bus_out    = port_reg.dout;
    assign host_data_bus_oe_out = port_reg.doe;

    // handshake pair and the ram hold
    assign access_enable_n_out  = port_reg.enable_n;
    assign transfer_ready_n_out = port_reg.ready_n;
    assign protocol_hold_out    = port_reg.hold;

endmodule

// ===== test/hbah_port_asserts.sv
// pin-level assertions for the host access port
// assumes bind into hbah_port with a single clock domain
`timescale 1ns/1ps

module hbah_port_asserts #(
    parameter int GRANT_MAX_CLKS = 560
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic host_select_n_in,
    input wire logic host_strobe_n_in,
    input wire logic read_write_in,
    input wire logic polarity_sel_strap_in,
    input wire logic transparent_sel_strap_in,
    input wire logic zero_wait_strap_in,
    input wire logic width_select_strap_in,
    input wire logic address_latch_enable_in,
    input wire logic host_data_bus_oe_out,
    input wire logic access_enable_n_out,
    input wire logic transfer_ready_n_out,
    input wire logic protocol_hold_out
);
    wire logic en_n  = access_enable_n_out;
    wire logic rdy_n = transfer_ready_n_out;
    wire logic oe    = host_data_bus_oe_out;
    wire logic stb_n = host_strobe_n_in;
    wire logic cfg   = !transparent_sel_strap_in && zero_wait_strap_in && width_select_strap_in;
    int        wait_reg;

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // counts edges a valid request has waited for the enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_reg <= 0;
        end else begin
            wait_reg <= (en_n && !host_select_n_in && !stb_n && cfg && address_latch_enable_in) ? wait_reg + 1 : 0;
        end
    end

    property p_grant; wait_reg <= GRANT_MAX_CLKS + 8; endproperty
    a_grant: assert property (p_grant)
        else $error("request waited too long for enable");
    property p_start; $fell(en_n) |-> !$past(stb_n, 3); endproperty
    a_start: assert property (p_start)
        else $error("enable fell before strobe was synchronised");
    property p_ready; $fell(en_n) |-> ##1 rdy_n [*2] ##[1:2] !rdy_n; endproperty
    a_ready: assert property (p_ready)
        else $error("ready not three or four clocks after enable");
    property p_release; $rose(stb_n) && !en_n |-> ##[1:3] (en_n && rdy_n && !oe && !protocol_hold_out); endproperty
    a_release: assert property (p_release)
        else $error("cycle not closed after strobe release");
    property p_stay; !en_n && !stb_n |=> !en_n; endproperty
    a_stay: assert property (p_stay)
        else $error("enable rose while strobe low");
    property p_ready_en; !rdy_n |-> !en_n; endproperty
    a_ready_en: assert property (p_ready_en)
        else $error("ready low outside an enabled cycle");
    property p_hold; protocol_hold_out == !en_n; endproperty
    a_hold: assert property (p_hold)
        else $error("ram hold disagrees with enable");
    property p_oe_rel; $fell(oe) |-> $past(stb_n, 2); endproperty
    a_oe_rel: assert property (p_oe_rel)
        else $error("read data released before strobe rose");
    property p_oe_dir; $rose(oe) |-> read_write_in == polarity_sel_strap_in; endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("data driven on a write");
endmodule

bind hbah_port hbah_port_asserts #(.GRANT_MAX_CLKS(GRANT_MAX_CLKS)) u_asserts (.clk_in, .rst_n_in,
    .host_select_n_in, .host_strobe_n_in, .read_write_in, .polarity_sel_strap_in, .transparent_sel_strap_in,
    .zero_wait_strap_in, .width_select_strap_in, .address_latch_enable_in, .host_data_bus_oe_out,
    .access_enable_n_out, .transfer_ready_n_out, .protocol_hold_out);

// ===== test/hbah_host_model.sv
// host processor model driving one access cycle per call
// assumes straps and address latch enable are driven by the bench
`timescale 1ns/1ps

module hbah_host_model
    import hbah_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       polarity_sel_in,
    input  wire logic       enable_n_in,
    input  wire logic       ready_n_in,
    input  wire hbah_data_t data_in,
    output      logic       select_n_out,
    output      logic       strobe_n_out,
    output      logic       mem_sel_out,
    output      logic       rw_out,
    output      hbah_addr_t addr_out,
    output      hbah_data_t data_out
);
    initial begin
        select_n_out = 1'b1;
        strobe_n_out = 1'b1;
        mem_sel_out  = 1'b0;
        rw_out       = 1'b0;
        addr_out     = 16'hFFFF;
        data_out     = 16'hFFFF;
    end

    // one cycle; enl and rdl are zero when the wait ran out
    task automatic cycle(input logic mem, input logic rd, input logic tied, input hbah_addr_t a,
                         input hbah_data_t d, input int hold, output hbah_data_t q, output int enl, output int rdl);
        enl = 0;
        rdl = 0;
        q   = ~d;
        @(posedge clk_in);
        select_n_out <= 1'b0;
        mem_sel_out  <= mem;
        rw_out       <= rd ~^ polarity_sel_in;
        addr_out     <= a;
        data_out     <= d;
        // select leads strobe by one edge unless both are tied
        if (!tied) @(posedge clk_in);
        strobe_n_out <= 1'b0;
        for (int i = 1; i <= 40 && enl == 0; i++) begin
            @(posedge clk_in);
            if (!enable_n_in) enl = i;
        end
        if (enl != 0) select_n_out <= 1'b1;
        for (int i = 1; i <= 8 && enl != 0 && rdl == 0; i++) begin
            @(posedge clk_in);
            if (!ready_n_in) rdl = i;
        end
        q = data_in;
        // strobe may stay low for as long as the host likes
        repeat (hold) @(posedge clk_in);
        @(posedge clk_in);
        strobe_n_out <= 1'b1;
        select_n_out <= 1'b1;
        addr_out     <= ~a;
        data_out     <= ~d;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ===== test/hbah_port_tb_top.sv
// self-checking bench for the host access port
// assumes the host model and checker bind compile alongside
`timescale 1ns/1ps

module hbah_port_tb_top
    import hbah_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       pol = 1'b1, transp = 1'b0, zw = 1'b1, wid = 1'b1, ale = 1'b1, busy = 1'b0;
    logic       sel_n, stb_n, msel, rw, oe, en_n, rdy_n, hold;
    hbah_addr_t addr;
    hbah_data_t wd, dout, q, bus;
    int         failures = 0, samples_checked = 0, enl, rdl;
    logic [3:0] bad_cfg [4] = '{4'hF, 4'h3, 4'h5, 4'h6};

    always #2.5 clk_in = ~clk_in;

    // a released data bus shows the inverse of the last word, so stale read data cannot pass
    assign bus = oe ? dout : ~dout;

    hbah_host_model host (.clk_in, .polarity_sel_in(pol), .enable_n_in(en_n), .ready_n_in(rdy_n),
        .data_in(bus), .select_n_out(sel_n), .strobe_n_out(stb_n), .mem_sel_out(msel), .rw_out(rw),
        .addr_out(addr), .data_out(wd));

    hbah_port #(.GRANT_MAX_CLKS(8)) uut (.clk_in, .rst_n_in, .host_select_n_in(sel_n),
        .host_strobe_n_in(stb_n), .mem_reg_sel_in(msel), .read_write_in(rw), .polarity_sel_strap_in(pol),
        .transparent_sel_strap_in(transp), .zero_wait_strap_in(zw), .width_select_strap_in(wid),
        .address_latch_enable_in(ale), .host_address_bus_in(addr), .host_data_bus_in(wd), .ram_busy_in(busy),
        .host_data_bus_out(dout), .host_data_bus_oe_out(oe), .access_enable_n_out(en_n),
        .transfer_ready_n_out(rdy_n), .protocol_hold_out(hold));

    task automatic results();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one host cycle; lat zero means the request must be ignored
    task automatic cyc(input logic mem, input logic rd, input logic tied, input hbah_addr_t a,
                       input hbah_data_t d, input int hld, input int lat, input hbah_data_t exp);
        host.cycle(mem, rd, tied, a, d, hld, q, enl, rdl);
        if (lat == 0) chk("ignored request", 16'h0, 16'(enl));
        else if (enl == 0 || rdl == 0) begin
            failures++;
            results();
        end else begin
            chk("ready latency", 16'(lat), 16'(rdl));
            if (rd) chk("read data", exp, q);
            chk("idle pins", 16'h000C, {12'h000, en_n, rdy_n, oe, hold});
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        chk("reset pins", 16'h000C, {12'h000, en_n, rdy_n, oe, hold});
        cyc(1'b1, 1'b0, 1'b0, 16'hF123, 16'h1234, 0, 3, 16'h0);
        cyc(1'b1, 1'b1, 1'b0, 16'h0123, 16'h0, 2, 3, 16'h1234);
        cyc(1'b0, 1'b0, 1'b1, 16'h0021, 16'hA5A5, 0, 4, 16'h0);
        cyc(1'b0, 1'b1, 1'b0, 16'hFFE1, 16'h0, 20, 3, 16'hA5A5);
        pol <= 1'b0;
        cyc(1'b0, 1'b0, 1'b0, 16'h0002, 16'h5A0F, 0, 3, 16'h0);
        cyc(1'b1, 1'b0, 1'b0, 16'h0002, 16'h0F0F, 0, 3, 16'h0);
        cyc(1'b0, 1'b1, 1'b0, 16'h0002, 16'h0, 0, 3, 16'h5A0F);
        cyc(1'b1, 1'b1, 1'b1, 16'h0002, 16'h0, 0, 4, 16'h0F0F);
        pol <= 1'b1;
        busy <= 1'b1;
        cyc(1'b1, 1'b1, 1'b0, 16'h0123, 16'h0, 0, 3, 16'h1234);
        chk("contended grant", 16'h1, 16'(enl >= 9 && enl <= 16));
        busy <= 1'b0;
        // each bad strap setting or a closed address latch refuses the write
        foreach (bad_cfg[k]) begin
            {transp, zw, wid, ale} <= bad_cfg[k];
            cyc(1'b0, 1'b0, 1'b0, 16'h0001, 16'hDEAD, 0, 0, 16'h0);
        end
        {transp, zw, wid, ale} <= 4'h7;
        cyc(1'b0, 1'b1, 1'b0, 16'h0001, 16'h0, 0, 3, 16'hA5A5);
        results();
    end
endmodule
